// >>> hw/line_sync.sv
// line_sync: two-flop synchroniser for a group of outside levels.
// assumes each bit is an independent level; no bus-wide coherence.
`timescale 1ns/1ns
`default_nettype none
module line_sync #(
  parameter int           W    = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s.meta   = din;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= {INIT, INIT};
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.stable;
endmodule : line_sync
`default_nettype wire

// >>> hw/twi_if.sv
// twi_if: the two bus wires with one open-drain driver set per party.
// assumes pull-ups: a line is high unless an enabled driver pulls it low.
`timescale 1ns/1ns
`default_nettype none
interface twi_if;
  logic mstSclOut;
  logic mstSclOe;
  logic mstSdaOut;
  logic mstSdaOe;
  logic slvSclOut;
  logic slvSclOe;
  logic slvSdaOut;
  logic slvSdaOe;
  logic scl;
  logic sda;

  // ****************
  // wired-and
  // ****************
  assign scl = !((mstSclOe && !mstSclOut) || (slvSclOe && !slvSclOut));
  assign sda = !((mstSdaOe && !mstSdaOut) || (slvSdaOe && !slvSdaOut));

  modport master (input scl, input sda,
                  output mstSclOut, output mstSclOe, output mstSdaOut, output mstSdaOe);
  modport slave  (input scl, input sda,
                  output slvSclOut, output slvSclOe, output slvSdaOut, output slvSdaOe);
endinterface : twi_if
`default_nettype wire

// >>> hw/twi_master.sv
// twi_master: far end; runs start, byte and stop sequences on command.
// assumes the user orders commands as a legal bus transfer.
`timescale 1ns/1ns
`default_nettype none
module twi_master import twi_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst,
  twi_if.master           bus,
  input  wire logic       cmdValid,
  output logic            cmdReady,
  input  wire cmd_e       cmdKind,
  input  wire logic [7:0] cmdData,
  input  wire logic       cmdLast,
  output logic            done,
  output logic      [7:0] rdData,
  output logic            ackSeen
);

  // ****************
  // state
  // ****************
  typedef enum logic [4:0] {
    M_IDLE  = 5'h01,
    M_HOLD  = 5'h02,
    M_START = 5'h04,
    M_BIT   = 5'h08,
    M_STOP  = 5'h10
  } mst_state_e;

  typedef struct packed {
    mst_state_e state;
    logic [1:0] ph;
    logic [7:0] tick;
    logic [3:0] cnt;
    logic [8:0] tx;
    logic [8:0] rx;
    logic       sclOe;
    logic       sdaOe;
    logic       done;
    logic [7:0] rdData;
    logic       ackSeen;
  } mst_s;

  localparam mst_s RESET_M = '{state: M_IDLE, default: '0};

  mst_s       s;
  mst_s       next_s;
  logic [1:0] syncd;
  logic       scl;
  logic       sda;
  logic       adv;
  logic       run;

  line_sync #(.W(2), .INIT(2'h3)) uSync (
    .clock (clock),
    .rst   (rst),
    .din   ({bus.scl, bus.sda}),
    .dout  (syncd)
  );

  assign scl      = syncd[1];
  assign sda      = syncd[0];
  // a released clock still low freezes the count
  assign run      = s.sclOe || scl;
  assign adv      = run && (s.tick == QUARTER_CYC - 8'h01);
  assign cmdReady = (s.state == M_IDLE) || (s.state == M_HOLD);

  // ****************
  // next state
  // ****************
  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    if (!cmdReady && run) begin
      next_s.tick = adv ? 8'h00 : s.tick + 8'h01;
    end
    if (adv) begin
      next_s.ph = s.ph + 2'h1;
    end
    unique case (s.state)
      M_IDLE, M_HOLD: begin
        next_s.tick = 8'h00;
        next_s.ph   = 2'h0;
        next_s.cnt  = 4'h0;
        if (cmdValid) begin
          if (cmdKind == CMD_START) begin
            next_s.state = M_START;
            next_s.sdaOe = 1'b0;
          end else if (s.state == M_HOLD) begin
            next_s.state = (cmdKind == CMD_STOP) ? M_STOP : M_BIT;
            next_s.tx    = (cmdKind == CMD_WRITE) ? {cmdData, 1'b1} : {8'hff, cmdLast};
          end
        end
      end
      M_START: begin
        if (adv) begin
          unique case (s.ph)
            2'h0: next_s.sclOe = 1'b0;
            2'h1: next_s.sdaOe = 1'b1;
            2'h2: next_s.sclOe = 1'b1;
            2'h3: begin
              next_s.state = M_HOLD;
              next_s.done  = 1'b1;
            end
          endcase
        end
      end
      M_BIT: begin
        if (adv) begin
          unique case (s.ph)
            2'h0: next_s.sdaOe = !s.tx[8];
            2'h1: next_s.sclOe = 1'b0;
            2'h2: next_s.rx    = {s.rx[7:0], sda};
            2'h3: begin
              next_s.sclOe = 1'b1;
              next_s.tx    = {s.tx[7:0], 1'b1};
              next_s.cnt   = s.cnt + 4'h1;
              if (s.cnt == SLOT_LAST) begin
                next_s.state   = M_HOLD;
                next_s.done    = 1'b1;
                next_s.rdData  = s.rx[8:1];
                next_s.ackSeen = !s.rx[0];
              end
            end
          endcase
        end
      end
      M_STOP: begin
        if (adv) begin
          unique case (s.ph)
            2'h0: next_s.sclOe = 1'b0;
            2'h1: next_s.sdaOe = 1'b0;
            2'h2: begin
              next_s.state = M_IDLE;
              next_s.done  = 1'b1;
            end
            2'h3: next_s.state = M_IDLE;
          endcase
        end else if (s.ph == 2'h0) begin
          next_s.sdaOe = 1'b1;
        end
      end
      default: next_s = RESET_M;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= RESET_M;
    end else begin
      s <= next_s;
    end
  end

  // ****************
  // outputs
  // ****************
  // open-drain: only ever pull low
  assign bus.mstSclOut = 1'b0;
  assign bus.mstSdaOut = 1'b0;
  assign bus.mstSclOe  = s.sclOe;
  assign bus.mstSdaOe  = s.sdaOe;
  assign done          = s.done;
  assign rdData        = s.rdData;
  assign ackSeen       = s.ackSeen;
endmodule : twi_master
`default_nettype wire

// >>> hw/twi_pkg.sv
// twi_pkg: shared constants for the two-wire address framing ends.
// assumes a 50 MHz system clock on both ends.
package twi_pkg;

  // ****************
  // timing
  // ****************
  localparam int         CLOCK_NS    = 20;
  localparam int         BIT_NS      = 10000;
  // quarter of a bit period, rounded down so the bus never runs slow
  localparam logic [7:0] QUARTER_CYC = 8'(BIT_NS / (4 * CLOCK_NS));

  // ****************
  // addressing
  // ****************
  // fixed part of own address; value is arbitrary
  localparam logic [3:0] FIXED_ADDR  = 4'h5;
  localparam logic [2:0] PROG_RESET  = 3'h0;
  localparam logic [6:0] GC_ADDR     = 7'h00;
  localparam logic [7:0] GC_RESET    = 8'h06;
  localparam logic [7:0] GC_LATCH    = 8'h04;
  localparam logic [3:0] RSV_LOW     = 4'h0;
  localparam logic [3:0] RSV_HIGH    = 4'hf;
  localparam logic       DIR_READ    = 1'b1;

  // ****************
  // framing
  // ****************
  localparam logic [2:0] BIT_LAST    = 3'h7;
  localparam logic [3:0] SLOT_LAST   = 4'h8;
  localparam logic [1:0] PIN_SETTLE  = 2'h2;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ  = 2'h2,
    CMD_STOP  = 2'h3
  } cmd_e;

endpackage : twi_pkg

// >>> hw/twi_slave.sv
// twi_slave: device end; 7-bit address recognition, ack, rx/tx bytes.
// assumes a bus master on twi_if and a user that answers hold promptly.
//
// Operation
// - hold scl low after acked byte
// - slow device may stretch each low phase; this slave stretches only the low phase after the ack slot
// - first byte: seven address bits, direction
// - master alone ends transfer with stop
// - repeated start may address another slave
// - read address: ack, then transmit
// - direction change needs repeated start, address
// - master receiver nacks last byte first
// - one ack slot after every byte
// - start resets framing to address byte
// - compare seven bits, pick receive/transmit
// - general call acked only when enabled
// - never ack the start byte
// - never ack legacy three-wire address
// - ignore other-format address
// - reserved addresses never match
// - 10-bit prefixes never match
// - own address: fixed part plus pins
// - declined byte leaves sda released
// - general call 06/04 relatch pins
// - nack from master releases sda
// - eight bits, msb first
`timescale 1ns/1ns
`default_nettype none
module twi_slave import twi_pkg::*; (
  input  wire logic       clock,
  input  wire logic       rst,
  twi_if.slave            bus,
  input  wire logic [2:0] addrPins,
  input  wire logic       gcEnable,
  input  wire logic       hold,
  input  wire logic [7:0] txData,
  output logic      [7:0] rxData,
  output logic            rxValid,
  output logic            txTaken,
  output logic            addressed,
  output logic            readMode,
  output logic            devReset
);

  // ****************
  // state
  // ****************
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_RECV  = 7'h02,
    S_WAITF = 7'h04,
    S_ACK   = 7'h08,
    S_HOLD  = 7'h10,
    S_TX    = 7'h20,
    S_TXACK = 7'h40
  } slv_state_e;

  typedef struct packed {
    slv_state_e state;
    logic [2:0] cnt;
    logic [7:0] shift;
    logic       first;
    logic       gc;
    logic       ackIt;
    logic       sclOe;
    logic       sdaOe;
    logic       sclPrev;
    logic       sdaPrev;
    logic [1:0] warm;
    logic [2:0] prog;
    logic [7:0] rxData;
    logic       rxValid;
    logic       txTaken;
    logic       addressed;
    logic       readMode;
    logic       devReset;
  } slv_s;

  localparam slv_s RESET_S = '{state: S_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1,
                               prog: PROG_RESET, default: '0};

  slv_s       s;
  slv_s       next_s;
  logic [4:0] syncd;
  logic [2:0] pins;
  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       startSeen;
  logic       stopSeen;
  logic [7:0] byteIn;
  logic [6:0] own;

  line_sync #(.W(5), .INIT(5'h03)) uSync (
    .clock (clock),
    .rst   (rst),
    .din   ({addrPins, bus.scl, bus.sda}),
    .dout  (syncd)
  );

  assign pins      = syncd[4:2];
  assign scl       = syncd[1];
  assign sda       = syncd[0];
  assign rise      = !s.sclPrev && scl;
  assign fall      = s.sclPrev && !scl;
  assign startSeen = s.sclPrev && scl && s.sdaPrev && !sda;
  assign stopSeen  = s.sclPrev && scl && !s.sdaPrev && sda;
  assign byteIn    = {s.shift[6:0], sda};
  assign own       = {FIXED_ADDR, s.prog};

  // ****************
  // decoding
  // ****************
  // reserved groups
  function automatic logic isReserved(input logic [6:0] a);
    isReserved = (a[6:3] == RSV_LOW) || (a[6:3] == RSV_HIGH);
  endfunction : isReserved

  // leaves the ack slot: either load a byte to send or arm the receiver
  function automatic slv_s enterNext(input slv_s c, input logic [7:0] d);
    slv_s r;
    r       = c;
    r.cnt   = '0;
    r.sclOe = 1'b0;
    if (c.readMode) begin
      r.state   = S_TX;
      r.shift   = d;
      r.sdaOe   = !d[7];
      r.txTaken = 1'b1;
    end else begin
      r.state = S_RECV;
      r.first = 1'b0;
    end
    return r;
  endfunction : enterNext

  // ****************
  // next state
  // ****************
  always_comb begin
    next_s          = s;
    next_s.rxValid  = 1'b0;
    next_s.txTaken  = 1'b0;
    next_s.devReset = 1'b0;
    next_s.sclPrev  = scl;
    next_s.sdaPrev  = sda;
    if (s.warm != 2'h3) begin
      next_s.warm = s.warm + 2'h1;
    end
    // pins caught once the synchroniser holds them after reset
    if (s.warm == PIN_SETTLE) begin
      next_s.prog = pins;
    end
    if (startSeen) begin
      next_s.state     = S_RECV;
      next_s.cnt       = '0;
      next_s.first     = 1'b1;
      next_s.gc        = 1'b0;
      next_s.sclOe     = 1'b0;
      next_s.sdaOe     = 1'b0;
      next_s.addressed = 1'b0;
    end else if (stopSeen) begin
      next_s.state     = S_IDLE;
      next_s.sclOe     = 1'b0;
      next_s.sdaOe     = 1'b0;
      next_s.addressed = 1'b0;
    end else begin
      unique case (s.state)
        S_IDLE: begin
          next_s.sdaOe = 1'b0;
        end
        S_RECV: begin
          if (rise) begin
            next_s.shift = byteIn;
            next_s.cnt   = s.cnt + 3'h1;
            if (s.cnt == BIT_LAST) begin
              next_s.state = S_WAITF;
              if (s.first) begin
                next_s.readMode = byteIn[0];
                if (byteIn[7:1] == GC_ADDR) begin
                  next_s.ackIt = gcEnable && (byteIn[0] != DIR_READ);
                  next_s.gc    = next_s.ackIt;
                end else begin
                  next_s.ackIt = (byteIn[7:1] == own) && !isReserved(own);
                end
                next_s.addressed = next_s.ackIt;
              end else if (s.gc) begin
                next_s.ackIt = (byteIn == GC_RESET) || (byteIn == GC_LATCH);
                if (next_s.ackIt) begin
                  next_s.prog = pins;
                end
                next_s.devReset = (byteIn == GC_RESET);
              end else begin
                next_s.ackIt   = 1'b1;
                next_s.rxData  = byteIn;
                next_s.rxValid = 1'b1;
              end
            end
          end
        end
        S_WAITF: begin
          if (fall) begin
            if (s.ackIt) begin
              next_s.sdaOe = 1'b1;
              next_s.state = S_ACK;
            end else begin
              next_s.state     = S_IDLE;
              next_s.addressed = 1'b0;
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            next_s.sdaOe = 1'b0;
            if (hold) begin
              next_s.sclOe = 1'b1;
              next_s.state = S_HOLD;
            end else begin
              next_s = enterNext(next_s, txData);
            end
          end
        end
        S_HOLD: begin
          if (!hold) begin
            next_s = enterNext(next_s, txData);
            // first bit settles on sda before scl is let go
            next_s.sclOe = s.readMode;
          end
        end
        S_TX: begin
          next_s.sclOe = 1'b0;
          if (fall) begin
            next_s.cnt = s.cnt + 3'h1;
            if (s.cnt == BIT_LAST) begin
              next_s.sdaOe = 1'b0;
              next_s.state = S_TXACK;
            end else begin
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.sdaOe = !s.shift[6];
            end
          end
        end
        S_TXACK: begin
          if (rise) begin
            if (!sda) begin
              next_s.state = S_ACK;
            end else begin
              next_s.state     = S_IDLE;
              next_s.addressed = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s <= RESET_S;
    end else begin
      s <= next_s;
    end
  end

  // ****************
  // outputs
  // ****************
  // drive low or release only
  assign bus.slvSclOut = 1'b0;
  assign bus.slvSdaOut = 1'b0;
  assign bus.slvSclOe  = s.sclOe;
  assign bus.slvSdaOe  = s.sdaOe;
  assign rxData        = s.rxData;
  assign rxValid       = s.rxValid;
  assign txTaken       = s.txTaken;
  assign addressed     = s.addressed;
  assign readMode      = s.readMode;
  assign devReset      = s.devReset;
endmodule : twi_slave
`default_nettype wire

// >>> test/twi_framing_sva.sv
// twi_framing_sva: wire-level checks beside the link of both ends.
// assumes one system clock; bus lines are registered-driven wired-and.
`timescale 1ns/1ns
`default_nettype none
module twi_framing_sva (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic mstSclOe,
  input wire logic mstSdaOe,
  input wire logic slvSclOut,
  input wire logic slvSdaOut,
  input wire logic slvSclOe,
  input wire logic slvSdaOe
);
  // ****************
  // bus decode
  // ****************
  logic       prevScl;
  logic       prevSda;
  logic [3:0] bitCnt;
  logic [7:0] shiftR;
  logic       first;
  logic [1:0] mode;
  logic       nacked;
  logic [2:0] startAge;
  logic       rise;
  logic       fall;
  logic       startEv;
  logic       stopEv;
  logic       ackSlot;
  logic       reserved;

  assign rise     = scl && !prevScl;
  assign fall     = !scl && prevScl;
  assign startEv  = scl && prevScl && prevSda && !sda;
  assign stopEv   = scl && prevScl && !prevSda && sda;
  assign ackSlot  = rise && (bitCnt == 4'h8);
  // general call is the only 0000xxx pattern a device may take
  assign reserved = (shiftR[7:4] == 4'h0 && shiftR != 8'h00) || shiftR[7:4] == 4'hf;

  // mode: 0 idle, 1 slave receives, 2 slave sends
  always_ff @(posedge clock) begin
    if (rst) begin
      prevScl  <= 1'b1;
      prevSda  <= 1'b1;
      bitCnt   <= 4'h0;
      shiftR   <= 8'h00;
      first    <= 1'b0;
      mode     <= 2'h0;
      nacked   <= 1'b0;
      startAge <= 3'h0;
    end else begin
      prevScl  <= scl;
      prevSda  <= sda;
      startAge <= (startAge == 3'h7) ? startAge : startAge + 3'h1;
      if (rise && bitCnt < 4'h8) shiftR <= {shiftR[6:0], sda};
      if (rise) bitCnt <= bitCnt + 4'h1;
      if (fall && bitCnt == 4'h9) begin
        bitCnt <= 4'h0;
        first  <= 1'b0;
      end
      if (ackSlot && first) mode <= sda ? 2'h0 : (shiftR[0] ? 2'h2 : 2'h1);
      if (ackSlot && !first && mode == 2'h2 && sda) nacked <= 1'b1;
      if (stopEv) mode <= 2'h0;
      if (startEv) begin
        bitCnt   <= 4'h0;
        first    <= 1'b1;
        nacked   <= 1'b0;
        startAge <= 3'h0;
        mode     <= 2'h0;
      end
    end
  end

  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_stretch;
    $rose(slvSclOe) |-> !scl && bitCnt == 4'h0;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch outside ack gap");

  property p_masterWaits;
    (!mstSclOe && !scl) |=> !mstSclOe && $stable(mstSdaOe);
  endproperty
  a_masterWaits: assert property (p_masterWaits) else $error("master moved in stretch");

  property p_addrQuiet;
    first && bitCnt < 4'h8 && startAge == 3'h7 |-> !slvSdaOe;
  endproperty
  a_addrQuiet: assert property (p_addrQuiet) else $error("slave drove address bits");

  property p_reservedNack;
    ackSlot && first && reserved |-> !slvSdaOe;
  endproperty
  a_reservedNack: assert property (p_reservedNack) else $error("reserved address acked");

  property p_dataAck;
    ackSlot && !first && mode == 2'h1 |-> !sda;
  endproperty
  a_dataAck: assert property (p_dataAck) else $error("written byte not acked");

  property p_txRelease;
    ackSlot && !first && mode == 2'h2 |-> !slvSdaOe;
  endproperty
  a_txRelease: assert property (p_txRelease) else $error("sender held ack slot");

  property p_nackRelease;
    nacked |-> !slvSdaOe;
  endproperty
  a_nackRelease: assert property (p_nackRelease) else $error("sda held after nack");

  property p_openDrain;
    !slvSclOut && !slvSdaOut;
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("slave drove a high level");

  c_stretch: cover property ($rose(slvSclOe));
  c_reserved: cover property (ackSlot && first && reserved);
  c_nacked: cover property ($rose(nacked));
endmodule : twi_framing_sva
`default_nettype wire

// >>> test/two_wire_address_framing_tb.sv
// two_wire_address_framing_tb: master end drives slave end over one link.
// assumes twi_pkg constants; each command waits for its done pulse.
`timescale 1ns/1ns
`default_nettype none
module two_wire_address_framing_tb import twi_pkg::*;;
  typedef struct packed {logic ca; logic ack; logic cr;} exp_s;
  localparam exp_s NONE = 3'b000;
  localparam exp_s ACK  = 3'b110;
  localparam exp_s NAK  = 3'b100;
  localparam exp_s RDA  = 3'b111;
  localparam exp_s RDN  = 3'b101;
  logic       clock, rst, cmdValid, cmdReady, cmdLast, done, ackSeen;
  logic       gcEnable, hold, rxValid, txTaken, addressed, readMode, devReset;
  cmd_e       cmdKind;
  logic [7:0] cmdData, rdData, txData, rxData, d;
  logic [2:0] addrPins, pins;
  logic [7:0] tbl [8];
  int         n_errors, checks_done, nRst;
  exp_s       ev;
  exp_s       qDone [$];
  logic [7:0] qRd [$];
  logic [7:0] qRx [$];

  twi_if link ();
  twi_master u_twi_master (.clock, .rst, .bus(link.master), .cmdValid, .cmdReady, .cmdKind,
                           .cmdData, .cmdLast, .done, .rdData, .ackSeen);
  twi_slave u_twi_slave (.clock, .rst, .bus(link.slave), .addrPins, .gcEnable, .hold,
                         .txData, .rxData, .rxValid, .txTaken, .addressed, .readMode,
                         .devReset);
  twi_framing_sva u_twi_framing_sva (.clock, .rst, .scl(link.scl), .sda(link.sda),
    .mstSclOe(link.mstSclOe), .mstSdaOe(link.mstSdaOe), .slvSclOut(link.slvSclOut),
    .slvSdaOut(link.slvSdaOut), .slvSclOe(link.slvSclOe), .slvSdaOe(link.slvSdaOe));

  always #10 clock = ~clock;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // one master command; returns on the edge of its done pulse
  task automatic cmd(input cmd_e k, input logic [7:0] dat, input logic l, input exp_s e);
    int n;
    cmdValid <= 1'b1;
    cmdKind  <= k;
    cmdData  <= dat;
    cmdLast  <= l;
    n = 0;
    do begin @(posedge clock); n++; end while (cmdReady !== 1'b1 && n < 20);
    cmdValid <= 1'b0;
    qDone.push_back(e);
    if (cmdReady !== 1'b1) begin n_errors++; conclude(); end
    n = 0;
    do begin @(posedge clock); n++; end while (done !== 1'b1 && n < 12000);
    if (done !== 1'b1) begin n_errors++; conclude(); end
  endtask : cmd

  // ****************
  // result watcher
  // ****************
  always @(posedge clock) begin
    if (!rst && done === 1'b1 && qDone.size() > 0) begin
      ev = qDone.pop_front();
      if (ev.ca) check(ackSeen, ev.ack);
      if (ev.cr) check(rdData, qRd.pop_front());
    end
    if (rxValid === 1'b1 && qRx.size() > 0) check(rxData, qRx.pop_front());
    if (devReset === 1'b1) nRst++;
    // next byte only after the slave has taken this one
    if (txTaken === 1'b1) begin
      qRd.push_back(txData);
      txData <= 8'($urandom);
    end
  end

  initial begin
    clock = 1'b0; rst = 1'b1; cmdValid = 1'b0; cmdKind = CMD_START; cmdData = 8'h00;
    cmdLast = 1'b0; gcEnable = 1'b0; hold = 1'b0; n_errors = 0; checks_done = 0; nRst = 0;
    void'($urandom(32'h0000_a111));
    pins = 3'($urandom);
    addrPins = pins;
    txData = 8'($urandom);
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    d = 8'($urandom);
    hold <= 1'b1;
    cmd(CMD_START, 8'h00, 1'b0, NONE);
    cmd(CMD_WRITE, {FIXED_ADDR, pins, 1'b0}, 1'b0, ACK);
    check(addressed, 1'b1);
    check(readMode, 1'b0);
    qRx.push_back(d);
    fork
      cmd(CMD_WRITE, d, 1'b0, ACK);
      begin
        repeat (2000) @(posedge clock);
        check(link.scl, 1'b0);
        hold <= 1'b0;
      end
    join
    $display("write with stretch over");
    cmd(CMD_START, 8'h00, 1'b0, NONE);
    cmd(CMD_WRITE, {FIXED_ADDR, pins, 1'b1}, 1'b0, ACK);
    check(readMode, 1'b1);
    cmd(CMD_READ, 8'h00, 1'b0, RDA);
    cmd(CMD_READ, 8'h00, 1'b1, RDN);
    cmd(CMD_STOP, 8'h00, 1'b0, NONE);
    $display("combined read over");
    tbl = '{8'h01, 8'h00, 8'h02, 8'h05, 8'h0c, 8'hfd, 8'hf2, {FIXED_ADDR, pins + 3'h1, 1'b0}};
    foreach (tbl[i]) begin
      // start byte tried with general call on, so only its direction refuses it
      gcEnable <= (tbl[i] == 8'h01);
      cmd(CMD_START, 8'h00, 1'b0, NONE);
      cmd(CMD_WRITE, tbl[i], 1'b0, NAK);
    end
    cmd(CMD_STOP, 8'h00, 1'b0, NONE);
    $display("refused addresses over");
    // pins move ahead of each latch; sync needs only a few cycles
    gcEnable <= 1'b1;
    addrPins <= pins ^ 3'h5;
    cmd(CMD_START, 8'h00, 1'b0, NONE);
    cmd(CMD_WRITE, {GC_ADDR, 1'b0}, 1'b0, ACK);
    cmd(CMD_WRITE, GC_RESET, 1'b0, ACK);
    cmd(CMD_START, 8'h00, 1'b0, NONE);
    cmd(CMD_WRITE, {FIXED_ADDR, pins ^ 3'h5, 1'b0}, 1'b0, ACK);
    addrPins <= pins ^ 3'h3;
    cmd(CMD_START, 8'h00, 1'b0, NONE);
    cmd(CMD_WRITE, {GC_ADDR, 1'b0}, 1'b0, ACK);
    cmd(CMD_WRITE, GC_LATCH, 1'b0, ACK);
    cmd(CMD_START, 8'h00, 1'b0, NONE);
    cmd(CMD_WRITE, {FIXED_ADDR, pins ^ 3'h3, 1'b0}, 1'b0, ACK);
    cmd(CMD_STOP, 8'h00, 1'b0, NONE);
    $display("general call over");
    // let the watcher take the last done note first
    @(posedge clock);
    check(8'(nRst), 8'h01);
    check(8'(qRx.size()), 8'h00);
    check(8'(qDone.size()), 8'h00);
    conclude();
  end
endmodule : two_wire_address_framing_tb
`default_nettype wire
